//--- shared/anat_pkg.sv
// What this block does
// - Select held for release minus assert, scaled
// - Bursts lengthen select by page words
// - Latch release placed from select, half-cycle shifts
// - Latch assert placed from select, half-cycle shifts
// - Read strobe assert placed from select
// - Single read strobe release placed from select
// - Burst read strobe release lengthened by pages
// - Later page addresses held page count scaled
// - Write strobe assert placed from select
// - Write strobe release placed from select
// - Address, enables, data valid from tick zero, select assert time before select
// - Byte enables valid cycle count plus pages
// - First read word sampled after access count
// - Divider zero gives bus clock equal functional
// - Scale bit zero means counts times one
// - Clock select zero picks high-speed divider
// - Functional clock never driven to pins
// - Four select outputs, one per region
// - Later page words sampled each page count
package anat_pkg;
    // Width of every programmed count field
    localparam int CW = 5;
    // Width of the half-period time base
    localparam int TW = 10;
    // Address and data widths, and count of select regions
    localparam int AW = 27;
    localparam int DW = 16;
    localparam int CSN = 4;
    // Clock select code for the high-speed divider output
    localparam logic [1:0] CLKSEL_HS = 2'h0;
    // High-speed divider output ratio, 2000 MHz over 15
    localparam int HS_NUM_MHZ = 2000;
    localparam int HS_DEN = 15;
    // Divider code for an undivided bus clock
    localparam logic [1:0] DIV_UNDIVIDED = 2'h0;
    // Scale bit code for times-one counts
    localparam logic SCALE_X1 = 1'h0;
    // Clock ticks per functional period; one tick is half a period
    localparam int FCLK_TICKS = 2;
    localparam logic [TW-1:0] TICK_ONE = 10'h001;
    // Idle pin levels
    localparam logic STROBE_IDLE = 1'h1;
    localparam logic [CSN-1:0] SEL_IDLE = 4'hF;
    localparam logic [AW-1:0] ADDR_RST = 27'h0000000;
    localparam logic [DW-1:0] DATA_RST = 16'h0000;

    // Sequencer states
    typedef enum logic {ANAT_IDLE, ANAT_RUN} anat_state_e;

    // Count to half-period ticks: count times scale, times two, plus shift
    function automatic logic [TW-1:0] anat_ht(input logic [CW-1:0] cnt, input logic scale,
                                             input logic shift);
        logic [TW-1:0] c;
        c = TW'(cnt) << scale;
        return (c << 1) + TW'(shift);
    endfunction : anat_ht

    // Extra ticks for (n - 1) page words, scaled
    function automatic logic [TW-1:0] anat_burst(input logic [1:0] nm1, input logic [CW-1:0] page,
                                                input logic scale);
        logic [TW-1:0] p;
        p = TW'(TW'(nm1) * TW'(page));
        return (p << scale) << 1;
    endfunction : anat_burst
endpackage : anat_pkg

//--- hdl/anat_timing.sv
module anat_timing (
    input wire logic clk,
    input wire logic rst_n,
    // Access request
    input wire logic req_valid,
    output logic req_ready,
    input wire logic req_write,
    input wire logic [1:0] req_region,
    input wire logic [1:0] req_words_m1,
    input wire logic [anat_pkg::AW-1:0] req_addr,
    input wire logic req_low_byte,
    input wire logic req_high_byte,
    input wire logic [anat_pkg::DW-1:0] wr_data,
    output logic wr_next,
    output logic [anat_pkg::DW-1:0] rd_data,
    output logic rd_valid,
    output logic done,
    // Timing configuration
    input wire logic [1:0] controller_clock_select,
    input wire logic [1:0] bus_clock_divider,
    input wire logic timing_scale_bit,
    input wire logic [anat_pkg::CW-1:0] select_assert_cycles,
    input wire logic [anat_pkg::CW-1:0] select_read_release_cycles,
    input wire logic [anat_pkg::CW-1:0] select_write_release_cycles,
    input wire logic select_half_cycle_shift,
    input wire logic [anat_pkg::CW-1:0] latch_assert_cycles,
    input wire logic [anat_pkg::CW-1:0] latch_read_release_cycles,
    input wire logic [anat_pkg::CW-1:0] latch_write_release_cycles,
    input wire logic latch_half_cycle_shift,
    input wire logic [anat_pkg::CW-1:0] read_strobe_assert_cycles,
    input wire logic [anat_pkg::CW-1:0] read_strobe_release_cycles,
    input wire logic read_strobe_half_cycle_shift,
    input wire logic [anat_pkg::CW-1:0] write_strobe_assert_cycles,
    input wire logic [anat_pkg::CW-1:0] write_strobe_release_cycles,
    input wire logic write_strobe_half_cycle_shift,
    input wire logic [anat_pkg::CW-1:0] read_total_cycles,
    input wire logic [anat_pkg::CW-1:0] write_total_cycles,
    input wire logic [anat_pkg::CW-1:0] read_sample_cycles,
    input wire logic [anat_pkg::CW-1:0] page_word_cycles,
    // Memory pins
    output logic external_bus_clock,
    output logic [anat_pkg::CSN-1:0] memory_select_n,
    output logic address_latch_n,
    output logic read_strobe_n,
    output logic write_strobe_n,
    output logic low_byte_enable_n,
    output logic high_byte_enable_n,
    output logic [anat_pkg::AW-1:0] memory_address_bus,
    input wire logic [anat_pkg::DW-1:0] memory_data_in,
    output logic [anat_pkg::DW-1:0] memory_data_out,
    output logic memory_data_oe
);
    localparam int TW = anat_pkg::TW;

    anat_pkg::anat_state_e state_q; // Sequencer state
    logic [TW-1:0] t_q; // Half-period ticks since access start
    logic [TW-1:0] tn; // Tick value being entered
    logic accept; // Request taken this edge
    logic [anat_pkg::CW-1:0] cfg_q [0:15]; // Latched count fields
    logic [anat_pkg::CW-1:0] cf [0:15]; // Live or latched counts
    logic [3:0] sh_q; // Latched shifts: select, latch, read, write
    logic [3:0] sh; // Live or latched shifts
    logic scale_q; // Latched scale bit
    logic sc; // Live or latched scale bit
    logic wr_q; // Latched direction
    logic [1:0] nm1_q; // Latched words minus one
    logic [1:0] nm1; // Live or latched words minus one
    logic [1:0] reg_q; // Latched region
    logic [1:0] w_q; // Current word index
    logic [TW-1:0] nb_q; // Tick of next word boundary
    logic [TW-1:0] t_cs_on, t_cs_off, t_al_on, t_al_off; // Event ticks
    logic [TW-1:0] t_rs_on, t_rs_off, t_ws_on, t_ws_off, t_end, t_acc, t_page, ext;
    logic [1:0] bclk_cnt_q; // Bus clock divider count

    // Request is taken only while idle and sourced from the high-speed divider
    assign accept = req_valid && req_ready;

    // Ticks step once per clock; one clock is half a functional period
    assign tn = (state_q == anat_pkg::ANAT_IDLE) ? '0 : t_q + anat_pkg::TICK_ONE;

    // Fields come from ports at acceptance and from latches afterwards
    always_comb begin
        if (state_q == anat_pkg::ANAT_IDLE) begin
            cf[0] = select_assert_cycles;
            cf[1] = req_write ? select_write_release_cycles : select_read_release_cycles;
            cf[2] = latch_assert_cycles;
            cf[3] = req_write ? latch_write_release_cycles : latch_read_release_cycles;
            cf[4] = read_strobe_assert_cycles;
            cf[5] = read_strobe_release_cycles;
            cf[6] = write_strobe_assert_cycles;
            cf[7] = write_strobe_release_cycles;
            cf[8] = req_write ? write_total_cycles : read_total_cycles;
            cf[9] = read_sample_cycles;
            cf[10] = page_word_cycles;
            for (int i = 11; i < 16; i++) begin
                cf[i] = '0;
            end
            sh = {write_strobe_half_cycle_shift, read_strobe_half_cycle_shift,
                  latch_half_cycle_shift, select_half_cycle_shift};
            sc = timing_scale_bit;
            nm1 = req_words_m1;
        end else begin
            for (int i = 0; i < 16; i++) begin
                cf[i] = cfg_q[i];
            end
            sh = sh_q;
            sc = scale_q;
            nm1 = nm1_q;
        end
    end

    // Event ticks; scale bit zero leaves every count times one
    always_comb begin
        ext = anat_pkg::anat_burst(nm1, cf[10], sc);
        t_cs_on = anat_pkg::anat_ht(cf[0], sc, sh[0]);
        t_cs_off = anat_pkg::anat_ht(cf[1], sc, sh[0]) + ext;
        t_al_on = anat_pkg::anat_ht(cf[2], sc, sh[1]);
        t_al_off = anat_pkg::anat_ht(cf[3], sc, sh[1]);
        t_rs_on = anat_pkg::anat_ht(cf[4], sc, sh[2]);
        t_rs_off = anat_pkg::anat_ht(cf[5], sc, sh[2]) + ext;
        t_ws_on = anat_pkg::anat_ht(cf[6], sc, sh[3]);
        t_ws_off = anat_pkg::anat_ht(cf[7], sc, sh[3]);
        t_end = anat_pkg::anat_ht(cf[8], sc, 1'b0) + ext;
        t_acc = anat_pkg::anat_ht(cf[9], sc, 1'b0);
        t_page = anat_pkg::anat_ht(cf[10], sc, 1'b0);
    end

    // Sequencer state and tick counter
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= anat_pkg::ANAT_IDLE;
            t_q <= '0;
        end else if (state_q == anat_pkg::ANAT_IDLE) begin
            if (accept) begin
                state_q <= anat_pkg::ANAT_RUN;
            end
            t_q <= '0;
        end else if (tn >= t_end) begin
            // Cycle time reached: back to idle
            state_q <= anat_pkg::ANAT_IDLE;
            t_q <= '0;
        end else begin
            t_q <= tn;
        end
    end

    // Configuration snapshot at acceptance
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < 16; i++) begin
                cfg_q[i] <= '0;
            end
            sh_q <= '0;
            scale_q <= anat_pkg::SCALE_X1;
            wr_q <= 1'b0;
            nm1_q <= '0;
            reg_q <= '0;
        end else if (accept) begin
            for (int i = 0; i < 16; i++) begin
                cfg_q[i] <= cf[i];
            end
            sh_q <= sh;
            scale_q <= sc;
            wr_q <= req_write;
            nm1_q <= req_words_m1;
            reg_q <= req_region;
        end
    end

    // Ready, done and strobe pins
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            req_ready <= 1'b0;
            done <= 1'b0;
            memory_select_n <= anat_pkg::SEL_IDLE;
            address_latch_n <= anat_pkg::STROBE_IDLE;
            read_strobe_n <= anat_pkg::STROBE_IDLE;
            write_strobe_n <= anat_pkg::STROBE_IDLE;
        end else begin
            // Refused while busy or off the high-speed source
            req_ready <= (controller_clock_select == anat_pkg::CLKSEL_HS) && !accept
                         && ((state_q == anat_pkg::ANAT_IDLE) || (tn >= t_end));
            done <= (state_q == anat_pkg::ANAT_RUN) && (tn >= t_end);
            if ((state_q == anat_pkg::ANAT_RUN || accept) && tn < t_end) begin
                // Each region drives only its own select line
                for (int i = 0; i < anat_pkg::CSN; i++) begin
                    memory_select_n[i] <= !((accept ? req_region : reg_q) == 2'(i)
                                           && tn >= t_cs_on && tn < t_cs_off);
                end
                address_latch_n <= !(tn >= t_al_on && tn < t_al_off);
                read_strobe_n <= (accept ? req_write : wr_q)
                                 || !(tn >= t_rs_on && tn < t_rs_off);
                write_strobe_n <= !(accept ? req_write : wr_q)
                                  || !(tn >= t_ws_on && tn < t_ws_off);
            end else begin
                memory_select_n <= anat_pkg::SEL_IDLE;
                address_latch_n <= anat_pkg::STROBE_IDLE;
                read_strobe_n <= anat_pkg::STROBE_IDLE;
                write_strobe_n <= anat_pkg::STROBE_IDLE;
            end
        end
    end

    // Address, byte enables, write data and per-word stepping
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            memory_address_bus <= anat_pkg::ADDR_RST;
            low_byte_enable_n <= anat_pkg::STROBE_IDLE;
            high_byte_enable_n <= anat_pkg::STROBE_IDLE;
            memory_data_out <= anat_pkg::DATA_RST;
            memory_data_oe <= 1'b0;
            w_q <= '0;
            nb_q <= '0;
            wr_next <= 1'b0;
        end else if (accept) begin
            // Driven at tick zero, ahead of the select by its assert time
            memory_address_bus <= req_addr;
            low_byte_enable_n <= !req_low_byte;
            high_byte_enable_n <= !req_high_byte;
            memory_data_out <= wr_data;
            memory_data_oe <= req_write;
            w_q <= '0;
            nb_q <= t_acc;
            wr_next <= 1'b0;
        end else if (state_q == anat_pkg::ANAT_RUN && tn >= t_end) begin
            // Enables released at the end of the cycle time
            low_byte_enable_n <= anat_pkg::STROBE_IDLE;
            high_byte_enable_n <= anat_pkg::STROBE_IDLE;
            memory_data_oe <= 1'b0;
            wr_next <= 1'b0;
        end else if (state_q == anat_pkg::ANAT_RUN && tn == nb_q && w_q < nm1_q) begin
            // Next page word: new address held one scaled page count
            memory_address_bus <= memory_address_bus + 27'h0000001;
            w_q <= w_q + 2'h1;
            nb_q <= nb_q + t_page;
            memory_data_out <= wr_data;
            wr_next <= wr_q;
        end else begin
            wr_next <= 1'b0;
        end
    end

    // Read data sampled at the access tick, then at each page boundary
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data <= anat_pkg::DATA_RST;
            rd_valid <= 1'b0;
        end else if (state_q == anat_pkg::ANAT_RUN && !wr_q && tn == nb_q && tn < t_end) begin
            rd_data <= memory_data_in;
            rd_valid <= 1'b1;
        end else begin
            rd_valid <= 1'b0;
        end
    end

    // Bus clock: toggles every divider-plus-one ticks; the internal time
    // base itself never leaves the block
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bclk_cnt_q <= '0;
            external_bus_clock <= 1'b0;
        end else if (bclk_cnt_q >= bus_clock_divider) begin
            // Divider zero: one full bus period per functional period
            bclk_cnt_q <= '0;
            external_bus_clock <= !external_bus_clock;
        end else begin
            bclk_cnt_q <= bclk_cnt_q + 2'h1;
        end
    end
endmodule : anat_timing

//--- sim/anat_timing_asserts.sv
module anat_timing_asserts (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic req_valid,
    input wire logic req_ready,
    input wire logic done,
    input wire logic rd_valid,
    input wire logic [1:0] controller_clock_select,
    input wire logic [1:0] bus_clock_divider,
    input wire logic external_bus_clock,
    input wire logic [anat_pkg::CSN-1:0] memory_select_n,
    input wire logic address_latch_n,
    input wire logic read_strobe_n,
    input wire logic write_strobe_n,
    input wire logic memory_data_oe
);
    // One domain; reset quiets every check
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // Cycles the divider has stayed at zero, saturating
    logic [2:0] zero_q;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            zero_q <= 3'h0;
        end else if (bus_clock_divider != 2'h0) begin
            zero_q <= 3'h0;
        end else if (zero_q != 3'h7) begin
            zero_q <= zero_q + 3'h1;
        end
    end
    property p_src; controller_clock_select != 2'h0 |=> !req_ready; endproperty
    a_src: assert property (p_src) else $error("ready with wrong source");
    property p_take; req_valid && req_ready |=> !req_ready; endproperty
    a_take: assert property (p_take) else $error("ready while busy");
    property p_sel; $onehot0(~memory_select_n); endproperty
    a_sel: assert property (p_sel) else $error("two selects low");
    property p_div; zero_q == 3'h7 |-> external_bus_clock != $past(external_bus_clock); endproperty
    a_div: assert property (p_div) else $error("bus clock not at functional rate");
    property p_idle;
        done |-> &memory_select_n && address_latch_n && read_strobe_n && write_strobe_n;
    endproperty
    a_idle: assert property (p_idle) else $error("pins busy at done");
    property p_rdy; done && controller_clock_select == 2'h0 |-> req_ready; endproperty
    a_rdy: assert property (p_rdy) else $error("no ready at done");
    property p_excl; !(!read_strobe_n && !write_strobe_n); endproperty
    a_excl: assert property (p_excl) else $error("both strobes low");
    property p_woe; !write_strobe_n |-> memory_data_oe; endproperty
    a_woe: assert property (p_woe) else $error("write without data drive");
    property p_roe; !read_strobe_n || rd_valid |-> !memory_data_oe; endproperty
    a_roe: assert property (p_roe) else $error("data driven during read");
endmodule : anat_timing_asserts

bind anat_timing anat_timing_asserts u_anat_timing_asserts (.clk, .rst_n, .req_valid,
    .req_ready, .done, .rd_valid, .controller_clock_select, .bus_clock_divider,
    .external_bus_clock, .memory_select_n, .address_latch_n, .read_strobe_n,
    .write_strobe_n, .memory_data_oe);

//--- sim/anat_flash_model.sv
module anat_flash_model #(
    parameter int LAG_NS = 0
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [anat_pkg::CSN-1:0] memory_select_n,
    input wire logic read_strobe_n,
    input wire logic [anat_pkg::AW-1:0] memory_address_bus,
    output logic [anat_pkg::DW-1:0] memory_data_in
);
    timeunit 1ns;
    timeprecision 100ps;
    // Addressed word while read-enabled, else a pattern that flips every cycle
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            memory_data_in <= 16'h0000;
        end else if (!(&memory_select_n) && !read_strobe_n) begin
            memory_data_in <= #(LAG_NS) memory_address_bus[15:0] ^ 16'hA5C3;
        end else begin
            memory_data_in <= #(LAG_NS) ~memory_data_in;
        end
    end
endmodule : anat_flash_model

//--- sim/anat_timing_test.sv
module anat_timing_test;
    timeunit 1ns;
    timeprecision 100ps;
    `define CHK(nm, ex, gt) begin total_checks++; if ((gt) !== (ex)) begin num_errors++; \
        $display("Error %s expected %h seen %h", nm, ex, gt); end end
    int num_errors = 0, total_checks = 0, tk = 0, wk = 0, nd = 0;
    string nm; // Name of the field being compared
    logic [31:0] lfsr = 32'hCEFD692C, x;
    logic [31:0] exp_q[$], rd_q[$], rec[10];
    logic [2:0] pv = 3'h7, cv;
    logic [26:0] cur_a, req_addr, memory_address_bus;
    logic clk, rst_n, req_valid, req_ready, req_write, req_low_byte, req_high_byte, wr_next;
    logic rd_valid, done, timing_scale_bit, external_bus_clock, address_latch_n, read_strobe_n;
    logic write_strobe_n, low_byte_enable_n, high_byte_enable_n, memory_data_oe;
    logic select_half_cycle_shift, latch_half_cycle_shift, read_strobe_half_cycle_shift;
    logic write_strobe_half_cycle_shift;
    logic [1:0] req_region, req_words_m1, controller_clock_select, bus_clock_divider;
    logic [3:0] memory_select_n;
    logic [15:0] wr_data, rd_data, memory_data_in, memory_data_out;
    logic [4:0] select_assert_cycles, select_read_release_cycles, select_write_release_cycles;
    logic [4:0] latch_assert_cycles, latch_read_release_cycles, latch_write_release_cycles;
    logic [4:0] read_strobe_assert_cycles, read_strobe_release_cycles, read_total_cycles;
    logic [4:0] write_strobe_assert_cycles, write_strobe_release_cycles, write_total_cycles;
    logic [4:0] read_sample_cycles, page_word_cycles;
    anat_timing u_anat_timing (.clk, .rst_n, .req_valid, .req_ready, .req_write, .req_region,
        .req_words_m1, .req_addr, .req_low_byte, .req_high_byte, .wr_data, .wr_next, .rd_data,
        .rd_valid, .done, .controller_clock_select, .bus_clock_divider, .timing_scale_bit,
        .select_assert_cycles, .select_read_release_cycles, .select_write_release_cycles,
        .select_half_cycle_shift, .latch_assert_cycles, .latch_read_release_cycles,
        .latch_write_release_cycles, .latch_half_cycle_shift, .read_strobe_assert_cycles,
        .read_strobe_release_cycles, .read_strobe_half_cycle_shift, .write_strobe_assert_cycles,
        .write_strobe_release_cycles, .write_strobe_half_cycle_shift, .read_total_cycles,
        .write_total_cycles, .read_sample_cycles, .page_word_cycles, .external_bus_clock,
        .memory_select_n, .address_latch_n, .read_strobe_n, .write_strobe_n, .low_byte_enable_n,
        .high_byte_enable_n, .memory_address_bus, .memory_data_in, .memory_data_out,
        .memory_data_oe);
    // Slow-answering memory on the far side
    anat_flash_model #(.LAG_NS(1)) u_anat_flash_model (.clk, .rst_n, .memory_select_n,
        .read_strobe_n, .memory_address_bus, .memory_data_in);
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // Next pseudo-random word
    function automatic logic [31:0] lf();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr;
    endfunction : lf
    // Count to half-period ticks
    function automatic int h(int c, int s);
        return c * (timing_scale_bit + 1) * 2 + s;
    endfunction : h
    // Write word for an address
    function automatic logic [15:0] wd(logic [26:0] a);
        return a[15:0] ^ 16'h3C5A;
    endfunction : wd
    // Random but well-ordered timing set and request
    task automatic cfg();
        {select_half_cycle_shift, latch_half_cycle_shift, read_strobe_half_cycle_shift,
            write_strobe_half_cycle_shift, timing_scale_bit} = 5'(lf());
        select_assert_cycles = 5'(lf() % 3);
        latch_assert_cycles = 5'(lf() % 3);
        latch_read_release_cycles = latch_assert_cycles + 5'(1 + lf() % 3);
        latch_write_release_cycles = latch_assert_cycles + 5'(1 + lf() % 3);
        // Read strobe after select, so the memory is selected before the first sample
        read_strobe_assert_cycles = select_assert_cycles + 5'(1 + lf() % 3);
        read_sample_cycles = read_strobe_assert_cycles + 5'h02;
        read_strobe_release_cycles = read_sample_cycles;
        write_strobe_assert_cycles = 5'(1 + lf() % 3);
        write_strobe_release_cycles = write_strobe_assert_cycles + 5'(1 + lf() % 3);
        select_read_release_cycles = 5'(8 + lf() % 3);
        select_write_release_cycles = 5'(8 + lf() % 3);
        read_total_cycles = select_read_release_cycles + 5'(1 + lf() % 2);
        write_total_cycles = select_write_release_cycles + 5'(1 + lf() % 2);
        page_word_cycles = 5'(1 + lf() % 3);
        {req_write, req_low_byte, req_high_byte, req_region, req_words_m1} = 7'(lf());
        req_addr = 27'(lf());
        bus_clock_divider = 2'(lf());
        wr_data = wd(req_addr);
    endtask : cfg
    // Bounded wait for the block to take requests
    task automatic idle();
        for (int w = 0; w < 300 && req_ready !== 1'b1; w++) begin
            @(posedge clk);
            #1;
        end
        // Ready never came back: count it and close the run
        if (req_ready !== 1'b1) begin
            num_errors++;
            test_done();
        end
    endtask : idle
    // One access with its expected pin ticks noted
    task automatic access();
        int n, e, b, p, so, k;
        idle();
        cfg();
        n = req_words_m1 + 1;
        p = h(page_word_cycles, 0);
        e = (n - 1) * p;
        b = h(read_sample_cycles, 0);
        so = h(write_strobe_release_cycles, write_strobe_half_cycle_shift);
        k = 0;
        for (int j = 0; j < n - 1; j++) k += (b + j * p <= so);
        exp_q.push_back(h(select_assert_cycles, select_half_cycle_shift));
        exp_q.push_back(h(req_write ? select_write_release_cycles : select_read_release_cycles,
            select_half_cycle_shift) + e);
        exp_q.push_back(h(latch_assert_cycles, latch_half_cycle_shift));
        exp_q.push_back(h(req_write ? latch_write_release_cycles : latch_read_release_cycles,
            latch_half_cycle_shift));
        if (req_write) begin
            exp_q.push_back(h(write_strobe_assert_cycles, write_strobe_half_cycle_shift));
            exp_q.push_back(so);
        end else begin
            exp_q.push_back(h(read_strobe_assert_cycles, read_strobe_half_cycle_shift));
            exp_q.push_back(h(read_strobe_release_cycles, read_strobe_half_cycle_shift) + e);
            for (int j = 0; j < n; j++) rd_q.push_back({16'(b + j * p),
                16'(req_addr + 27'(j)) ^ 16'hA5C3});
        end
        exp_q.push_back(h(req_write ? write_total_cycles : read_total_cycles, 0) + e);
        exp_q.push_back({3'h0, !req_low_byte, !req_high_byte, req_addr});
        exp_q.push_back(req_write ? {16'h0001, wd(req_addr + 27'(k))} : 32'h0);
        // Byte enables still held in the cycle before the end
        exp_q.push_back({30'h0, !req_low_byte, !req_high_byte});
        req_valid = 1'b1;
        @(posedge clk);
        #1;
        req_valid = 1'b0;
        cur_a = req_addr;
        wk = 2;
        wr_data = wd(req_addr + 27'h1);
    endtask : access
    // Tick counter and pin watcher; checks each result against the oldest note
    always @(posedge clk) begin
        tk = (req_valid && req_ready) ? 0 : tk + 1;
        #1;
        cv = {read_strobe_n & write_strobe_n, address_latch_n, &memory_select_n};
        for (int i = 0; i < 3; i++) begin
            if (pv[i] && !cv[i]) rec[2 * i] = tk;
            if (!pv[i] && cv[i]) rec[2 * i + 1] = tk;
        end
        if (pv[0] && !cv[0]) rec[7] = {3'h0, low_byte_enable_n, high_byte_enable_n,
            memory_address_bus};
        if (!pv[2] && cv[2]) rec[8] = memory_data_oe ? {16'h0001, memory_data_out} : 32'h0;
        pv = cv;
        if (wr_next === 1'b1) begin
            wr_data = wd(cur_a + 27'(wk));
            wk++;
        end
        if (rd_valid === 1'b1) begin
            x = rd_q.size() > 0 ? rd_q.pop_front() : 32'hX;
            `CHK("read word", x, {tk[15:0], rd_data})
        end
        if (done === 1'b1) begin
            rec[6] = tk;
            // Take each note once, then compare
            for (int i = 0; i < 10; i++) begin
                x = exp_q.pop_front();
                nm = $sformatf("field %0d", i);
                `CHK(nm, x, rec[i])
            end
            `CHK("enables at end", 2'h3, {low_byte_enable_n, high_byte_enable_n})
            nd++;
            $display("access %0d finished", nd);
        end
        // Enables of this cycle, seen by the next done
        rec[9] = {30'h0, low_byte_enable_n, high_byte_enable_n};
    end
    // Verdict and end of run
    task automatic test_done();
        $display("checks %0d mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : test_done
    // Main sequence
    initial begin
        rst_n = 1'b0;
        req_valid = 1'b0;
        controller_clock_select = 2'h0;
        cfg();
        repeat (16) @(posedge clk);
        #1;
        rst_n = 1'b1;
        @(posedge clk);
        #1;
        for (int i = 0; i < 40; i++) access();
        idle();
        controller_clock_select = 2'h1;
        @(posedge clk);
        #1;
        req_valid = 1'b1;
        repeat (8) @(posedge clk);
        #1;
        `CHK("ready refused", 1'b0, req_ready)
        req_valid = 1'b0;
        controller_clock_select = 2'h0;
        $display("refusal test finished");
        access();
        idle();
        repeat (2) @(posedge clk);
        `CHK("notes left", 32'h0, 32'(exp_q.size() + rd_q.size()))
        test_done();
    end
    // Watchdog against a hang
    initial begin
        #60000;
        num_errors++;
        test_done();
    end
endmodule : anat_timing_test
